/* File: rtl/ufh_char_timer.sv */
// Bit-time tick from the reference clock and divisor, and character length in bits
`timescale 1ns/1ns
`include "ufh_params.svh"
module ufh_char_timer (
  // Clock and reset
  input wire logic  aclk,
  input wire logic  aresetn,
  // Line settings
  input wire logic [15:0] divisor,
  input wire logic [7:0]  lcr,
  // Timing
  output logic            bit_tick,
  output logic [3:0]      char_bits
);
  import ufh_pkg::*;
  ufh_tmr_st_t s;
  ufh_tmr_st_t next_s;
  logic [31:0] sum;

  assign bit_tick = s.tick;
  // Start, data, parity and one or two stop bits; second stop bit counts too
  assign char_bits = 4'h7 + {2'b00, lcr[`UFH_LCR_WLS]} + {3'b000, lcr[`UFH_LCR_PEN]}
                   + {3'b000, lcr[`UFH_LCR_STB]};

  always_comb
  begin
    next_s      = s;
    next_s.tick = 1'b0;
    // Fractional accumulator: the reference rate is not a divisor of the bus clock
    sum = 32'(s.acc) + 32'(`UFH_REF_HZ);
    if (sum >= 32'(`UFH_CLK_HZ))
    begin
      next_s.acc = 24'(sum - 32'(`UFH_CLK_HZ));
      if (s.div_cnt + 16'h0001 >= divisor)
      begin
        next_s.div_cnt = 16'h0000;
        next_s.sub     = s.sub + 4'h1;
        next_s.tick    = (s.sub == `UFH_OVERSAMPLE);
      end
      else
        next_s.div_cnt = s.div_cnt + 16'h0001;
    end
    else
      next_s.acc = sum[23:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tick_spacing: assert property (bit_tick |=> !bit_tick [*8])
    else $error("bit ticks closer than a bit time");
  a_char_length: assert property (char_bits >= 4'h7 && char_bits <= 4'hC)
    else $error("character length out of range");
endmodule : ufh_char_timer

/* File: rtl/ufh_fifo.sv */
// Sixteen-byte character FIFO
`timescale 1ns/1ns
`include "ufh_params.svh"
module ufh_fifo (
  // Clock and reset
  input wire logic  aclk,
  input wire logic  aresetn,
  // FIFO port
  ufh_fifo_if.owner f
);
  import ufh_pkg::*;
  ufh_fifo_st_t s;
  ufh_fifo_st_t next_s;
  logic         push_ok;
  logic         pop_ok;

  assign f.count = s.cnt;
  assign f.rdata = s.mem[s.rd];

  always_comb
  begin
    next_s  = s;
    push_ok = f.push && (s.cnt != `UFH_FIFO_DEPTH);
    pop_ok  = f.pop && (s.cnt != 5'h00);
    if (f.flush)
    begin
      next_s.rd  = 4'h0;
      next_s.wr  = 4'h0;
      next_s.cnt = 5'h00;
    end
    else
    begin
      if (push_ok)
      begin
        next_s.mem[s.wr] = f.wdata;
        next_s.wr        = s.wr + 4'h1;
      end
      if (pop_ok)
        next_s.rd = s.rd + 4'h1;
      next_s.cnt = s.cnt + 5'(push_ok) - 5'(pop_ok);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_depth_bound: assert property (s.cnt <= `UFH_FIFO_DEPTH)
    else $error("fifo count above depth");
  a_push_counts: assert property (push_ok && !pop_ok && !f.flush |=> s.cnt == $past(s.cnt) + 5'h01)
    else $error("push did not raise count");
endmodule : ufh_fifo

/* File: rtl/ufh_fifo_if.sv */
// Push, pop and level signals between the host logic and one FIFO
`timescale 1ns/1ns
interface ufh_fifo_if;
  logic               push;
  ufh_pkg::ufh_byte_t wdata;
  logic               pop;
  logic               flush;
  ufh_pkg::ufh_byte_t rdata;
  logic [4:0]         count;
  modport owner (input push, wdata, pop, flush, output rdata, count);
  modport user  (output push, wdata, pop, flush, input rdata, count);
endinterface : ufh_fifo_if

/* File: rtl/ufh_host_if.sv */
// UART FIFO host interface: register file, FIFOs, timeout and interrupt identity
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "ufh_params.svh"
module ufh_host_if (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // AXI4-Lite write
  input wire logic                    awvalid,
  output logic                        awready,
  input wire logic [`UFH_ADDR_W-1:0]  awaddr,
  input wire logic                    wvalid,
  output logic                        wready,
  input wire logic [31:0]             wdata,
  input wire logic [3:0]              wstrb,
  output logic                        bvalid,
  input wire logic                    bready,
  output logic [1:0]                  bresp,
  // AXI4-Lite read
  input wire logic                    arvalid,
  output logic                        arready,
  input wire logic [`UFH_ADDR_W-1:0]  araddr,
  output logic                        rvalid,
  input wire logic                    rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // Character stream from the line receiver
  input wire logic                    rx_char_valid,
  input wire ufh_pkg::ufh_byte_t      rx_char_data,
  // Character stream to the line transmitter
  output logic                        tx_char_valid,
  input wire logic                    tx_char_ready,
  output ufh_pkg::ufh_byte_t          tx_char_data,
  // Host interrupt
  output logic                        host_interrupt_out
);
  import ufh_pkg::*;

  typedef struct packed {
    logic       aw_ok;
    logic       w_ok;
    logic       wen;
    logic       wbad;
    logic [2:0] widx;
    ufh_byte_t  wdat;
    logic       bvalid;
    logic       rvalid;
    logic       rbad;
    ufh_byte_t  rdata;
    logic [3:0] ier;
    ufh_byte_t  lcr;
    ufh_byte_t  dll;
    ufh_byte_t  dlm;
    ufh_byte_t  scr;
    logic       fifo_en;
    logic [1:0] trig;
    logic       oe;
    logic       irq;
    logic [7:0] to_cnt;
    logic       tx_holding_empty_flag_d;
    logic       seen_two;
    logic       first_tx;
    logic       dly_on;
    logic [3:0] dly_cnt;
    logic       tx_ind;
    logic       thr_irq;
    logic       tx_valid;
    ufh_byte_t  tx_data;
  } ufh_top_st_t;

  localparam ufh_top_st_t RST = '{lcr: `UFH_RST_LCR, dll: `UFH_RST_DLL, tx_holding_empty_flag_d: 1'b1,
                                  tx_ind: 1'b1, default: '0};

  ufh_top_st_t s;
  ufh_top_st_t next_s;
  ufh_fifo_if  rx_f ();
  ufh_fifo_if  tx_f ();
  logic        bit_tick;
  logic [3:0]  char_bits;
  logic        divisor_access_bit;
  logic        wr;
  logic        wr_buf;
  logic        fcr_wr;
  logic        rd_do;
  logic [2:0]  ridx;
  logic        rd_buf;
  logic        rd_iir;
  logic        rd_lsr;
  logic [4:0]  cap;
  logic [4:0]  trig_lvl;
  logic        rx_lvl;
  logic        tmo;
  logic        tx_holding_empty_flag;
  logic        ovr;
  logic        thr_clr;
  ufh_id_t     id;
  ufh_byte_t   rd_val;

  ufh_fifo u_rx_fifo (.aclk(aclk), .aresetn(aresetn), .f(rx_f.owner));
  ufh_fifo u_tx_fifo (.aclk(aclk), .aresetn(aresetn), .f(tx_f.owner));
  ufh_char_timer u_timer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .divisor   ({s.dlm, s.dll}),
    .lcr       (s.lcr),
    .bit_tick  (bit_tick),
    .char_bits (char_bits)
  );

  assign awready = !s.aw_ok && !s.bvalid;
  assign wready  = !s.w_ok && !s.bvalid;
  assign bvalid  = s.bvalid;
  assign bresp   = s.wbad ? 2'h2 : 2'h0;
  assign arready = !s.rvalid;
  assign rvalid  = s.rvalid;
  assign rdata   = {24'h000000, s.rdata};
  assign rresp   = s.rbad ? 2'h2 : 2'h0;
  assign tx_char_valid      = s.tx_valid;
  assign tx_char_data       = s.tx_data;
  assign host_interrupt_out = s.irq;

  // Register selection and strobes
  assign divisor_access_bit   = s.lcr[`UFH_LCR_DIVISOR_ACCESS_BIT];
  assign wr     = s.aw_ok && s.w_ok && s.wen && !s.wbad && !s.bvalid;
  assign wr_buf = wr && (s.widx == `UFH_IDX_BUF) && !divisor_access_bit;
  assign fcr_wr = wr && (s.widx == `UFH_IDX_IIR);
  assign rd_do  = arvalid && !s.rvalid;
  assign ridx   = araddr[4:2];
  assign rd_buf = rd_do && (araddr[7:5] == 3'h0) && (ridx == `UFH_IDX_BUF) && !divisor_access_bit;
  assign rd_iir = rd_do && (araddr[7:5] == 3'h0) && (ridx == `UFH_IDX_IIR);
  assign rd_lsr = rd_do && (araddr[7:5] == 3'h0) && (ridx == `UFH_IDX_LSR);

  // Legacy mode is a FIFO capped at one entry
  assign cap = s.fifo_en ? `UFH_FIFO_DEPTH : 5'h01;
  assign trig_lvl = (s.trig == 2'h0) ? `UFH_TRIG_0 : (s.trig == 2'h1) ? `UFH_TRIG_1 :
                    (s.trig == 2'h2) ? `UFH_TRIG_2 : `UFH_TRIG_3;
  assign rx_lvl = s.fifo_en ? (rx_f.count >= trig_lvl) : (rx_f.count != 5'h00);
  assign tmo    = s.fifo_en && (rx_f.count != 5'h00)
                  && (s.to_cnt > 8'(`UFH_TMO_CHARS * char_bits));
  assign tx_holding_empty_flag   = (tx_f.count == 5'h00);
  assign ovr    = rx_char_valid && (rx_f.count >= cap) && !rx_f.flush;

  // Receive data cannot be stalled: a character with no room is dropped, and flagged except in a receive flush cycle
  assign rx_f.push  = rx_char_valid && (rx_f.count < cap);
  assign rx_f.wdata = rx_char_data;
  assign rx_f.pop   = rd_buf;
  assign rx_f.flush = fcr_wr && ((s.wdat[`UFH_FCR_EN] != s.fifo_en) || s.wdat[`UFH_FCR_RXRST]);
  assign tx_f.push  = wr_buf && (tx_f.count < cap);
  assign tx_f.wdata = s.wdat;
  assign tx_f.pop   = (tx_f.count != 5'h00) && (!s.tx_valid || tx_char_ready);
  assign tx_f.flush = fcr_wr && ((s.wdat[`UFH_FCR_EN] != s.fifo_en) || s.wdat[`UFH_FCR_TXRST]);

  // Interrupt identity in priority order; nothing is reported while its enable is clear
  always_comb
  begin
    if (s.ier[`UFH_IER_RX] && rx_lvl)
      id = UFH_ID_RDA;
    else if (s.ier[`UFH_IER_RX] && tmo)
      id = UFH_ID_TMO;
    else if (s.ier[`UFH_IER_TX] && s.thr_irq)
      id = UFH_ID_THR;
    else
      id = UFH_ID_NONE;
  end

  always_comb
  begin
    if (ridx == `UFH_IDX_BUF)
      rd_val = divisor_access_bit ? s.dll : rx_f.rdata;
    else if (ridx == `UFH_IDX_IER)
      rd_val = divisor_access_bit ? s.dlm : {4'h0, s.ier};
    else if (ridx == `UFH_IDX_IIR)
      rd_val = {s.fifo_en, s.fifo_en, 2'h0, id};
    else if (ridx == `UFH_IDX_LCR)
      rd_val = s.lcr;
    else if (ridx == `UFH_IDX_LSR)
      rd_val = {1'b0, tx_holding_empty_flag && !s.tx_valid, tx_holding_empty_flag, 3'h0, s.oe, rx_f.count != 5'h00};
    else if (ridx == `UFH_IDX_SCR)
      rd_val = s.scr;
    else
      rd_val = 8'h00;
  end

  always_comb
  begin
    next_s = s;
    // Bus: address and data may arrive in either order; the write commits once both are held
    if (s.aw_ok && s.w_ok && !s.bvalid)
    begin
      next_s.aw_ok  = 1'b0;
      next_s.w_ok   = 1'b0;
      next_s.bvalid = 1'b1;
    end
    if (awvalid && awready)
    begin
      next_s.aw_ok = 1'b1;
      next_s.widx  = awaddr[4:2];
      next_s.wbad  = (awaddr[7:5] != 3'h0);
    end
    if (wvalid && wready)
    begin
      next_s.w_ok = 1'b1;
      next_s.wdat = wdata[7:0];
      next_s.wen  = wstrb[0];
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (rd_do)
    begin
      next_s.rvalid = 1'b1;
      next_s.rbad   = (araddr[7:5] != 3'h0);
      next_s.rdata  = (araddr[7:5] != 3'h0) ? 8'h00 : rd_val;
    end
    else if (s.rvalid && rready)
      next_s.rvalid = 1'b0;

    if (wr)
    begin
      if (s.widx == `UFH_IDX_BUF)
      begin
        if (divisor_access_bit)
          next_s.dll = s.wdat;
      end
      else if (s.widx == `UFH_IDX_IER)
      begin
        if (divisor_access_bit)
          next_s.dlm = s.wdat;
        else
          next_s.ier = s.wdat[3:0];
      end
      else if (s.widx == `UFH_IDX_IIR)
      begin
        next_s.fifo_en = s.wdat[`UFH_FCR_EN];
        next_s.trig    = s.wdat[`UFH_FCR_TRIG];
        if (s.wdat[`UFH_FCR_EN] && !s.fifo_en)
          next_s.first_tx = 1'b1;
      end
      else if (s.widx == `UFH_IDX_LCR)
        next_s.lcr = s.wdat;
      else if (s.widx == `UFH_IDX_SCR)
        next_s.scr = s.wdat;
    end

    next_s.oe = ovr || (s.oe && !rd_lsr);

    // Silence counter in bit times, restarted by an accepted arrival, a receive buffer read or a receive flush
    if (rx_f.push || rx_f.pop || rx_f.flush)
      next_s.to_cnt = 8'h00;
    else if (bit_tick && (s.to_cnt != 8'hFF))
      next_s.to_cnt = s.to_cnt + 8'h01;

    if (tx_f.pop)
    begin
      next_s.tx_valid = 1'b1;
      next_s.tx_data  = tx_f.rdata;
    end
    else if (tx_char_ready)
      next_s.tx_valid = 1'b0;

    // Transmit empty indication, held back in FIFO mode while a lone last character may still be leaving, except on the first empty after enabling
    next_s.tx_holding_empty_flag_d = tx_holding_empty_flag;
    if (tx_f.count >= 5'h02)
      next_s.seen_two = 1'b1;
    if (tx_holding_empty_flag && !s.tx_holding_empty_flag_d)
    begin
      next_s.seen_two = 1'b0;
      if (s.fifo_en && !s.first_tx && !s.seen_two)
      begin
        next_s.dly_on  = 1'b1;
        next_s.dly_cnt = char_bits - 4'h1;
      end
      else
      begin
        next_s.tx_ind   = 1'b1;
        next_s.first_tx = 1'b0;
      end
    end
    else if (!tx_holding_empty_flag)
    begin
      next_s.tx_ind = 1'b0;
      next_s.dly_on = 1'b0;
    end
    else if (s.dly_on && bit_tick)
    begin
      if (s.dly_cnt <= 4'h1)
      begin
        next_s.dly_on   = 1'b0;
        next_s.tx_ind   = 1'b1;
        next_s.first_tx = 1'b0;
      end
      else
        next_s.dly_cnt = s.dly_cnt - 4'h1;
    end

    // A new empty event wins over a clear in the same cycle
    thr_clr = wr_buf || (rd_iir && (id == UFH_ID_THR));
    next_s.thr_irq = (next_s.tx_ind && !s.tx_ind)
                     || (next_s.ier[`UFH_IER_TX] && !s.ier[`UFH_IER_TX] && next_s.tx_ind)
                     || (s.thr_irq && !thr_clr);
    next_s.irq = (id != UFH_ID_NONE);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= RST;
    else
      s <= next_s;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_fifo_mode_on: assert property (fcr_wr && s.wdat[0] |=> s.fifo_en && cap == 5'h10)
    else $error("FIFO enable write did not open both FIFOs");
  a_legacy_single: assert property (!s.fifo_en |-> rx_f.count <= 5'h01 && tx_f.count <= 5'h01)
    else $error("legacy mode holds more than one character");
  a_rx_read_oldest: assert property (rd_buf && rx_f.count != 5'h00 |=> s.rdata == $past(rx_f.rdata))
    else $error("receive read did not return the oldest character");
  a_ready_flag: assert property (rd_lsr |=> s.rdata[0] == ($past(rx_f.count) != 5'h00))
    else $error("data ready flag missing");
  a_trigger_code: assert property (s.fifo_en && s.ier[0] && rx_f.count >= trig_lvl |-> id == UFH_ID_RDA)
    else $error("trigger level did not give code 4h");
  a_trigger_irq: assert property (s.fifo_en && s.ier[0] && rx_f.count >= trig_lvl |=> host_interrupt_out)
    else $error("interrupt not raised at trigger level");
  a_timeout_code: assert property (s.ier[0] && !rx_lvl && tmo |-> id == UFH_ID_TMO)
    else $error("timeout code missing");
  a_thr_write_clr: assert property (wr_buf && !next_s.tx_ind |=> !s.thr_irq)
    else $error("transmit write did not clear code 2h");
  a_tx_delayed: assert property ($rose(tx_holding_empty_flag) && s.fifo_en && !s.first_tx && !s.seen_two |=> !s.tx_ind [*2])
    else $error("transmit empty not delayed");
  a_first_tx_now: assert property ($rose(tx_holding_empty_flag) && s.first_tx |=> s.tx_ind)
    else $error("first transmit interrupt was delayed");
  a_no_enable_quiet: assert property (s.ier == 4'h0 |=> !host_interrupt_out)
    else $error("interrupt with all enables clear");
  c_trigger_hit: cover property (s.fifo_en && s.trig == 2'h3 && rx_lvl);
  c_timeout_seen: cover property (id == UFH_ID_TMO);
  c_tx_delay_done: cover property (s.dly_on ##1 !s.dly_on && s.tx_ind);
  c_tx_irq_clr: cover property (s.thr_irq ##1 !s.thr_irq);
endmodule : ufh_host_if

/* File: rtl/ufh_params.svh */
// Register map, field positions, reset values and timing for the UART FIFO host block
`ifndef UFH_PARAMS_SVH
`define UFH_PARAMS_SVH
`define UFH_ADDR_W        8
`define UFH_IDX_BUF       3'h0
`define UFH_IDX_IER       3'h1
`define UFH_IDX_IIR       3'h2
`define UFH_IDX_LCR       3'h3
`define UFH_IDX_LSR       3'h5
`define UFH_IDX_SCR       3'h7
`define UFH_FIFO_DEPTH    5'h10
`define UFH_FCR_EN        0
`define UFH_FCR_RXRST     1
`define UFH_FCR_TXRST     2
`define UFH_FCR_TRIG      7:6
`define UFH_LCR_WLS       1:0
`define UFH_LCR_STB       2
`define UFH_LCR_PEN       3
`define UFH_LCR_DIVISOR_ACCESS_BIT      7
`define UFH_IER_RX        0
`define UFH_IER_TX        1
`define UFH_RST_LCR       8'h00
`define UFH_RST_DLL       8'h01
`define UFH_TRIG_0        5'h01
`define UFH_TRIG_1        5'h04
`define UFH_TRIG_2        5'h08
`define UFH_TRIG_3        5'h0E
`define UFH_TMO_CHARS     4
`define UFH_OVERSAMPLE    4'hF
`define UFH_CLK_PERIOD_NS 100
`define UFH_CLK_HZ        (1000000000 / `UFH_CLK_PERIOD_NS)
`define UFH_REF_HZ        1843200
`endif

/* File: rtl/ufh_pkg.sv */
// Types shared by the UART FIFO host block
package ufh_pkg;
  typedef logic [7:0] ufh_byte_t;
  typedef enum logic [3:0] {
    UFH_ID_NONE = 4'h1,
    UFH_ID_THR  = 4'h2,
    UFH_ID_RDA  = 4'h4,
    UFH_ID_TMO  = 4'hC
  } ufh_id_t;
  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [3:0]       rd;
    logic [3:0]       wr;
    logic [4:0]       cnt;
  } ufh_fifo_st_t;
  typedef struct packed {
    logic [23:0] acc;
    logic [15:0] div_cnt;
    logic [3:0]  sub;
    logic        tick;
  } ufh_tmr_st_t;
endpackage : ufh_pkg

/* File: tb/uart_fifo_host_interface_test.sv */
// Self-checking bench for the UART FIFO host block
`timescale 1ns/1ns
module uart_fifo_host_interface_test;
  import ufh_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        rx_char_valid, tx_char_valid, tx_char_ready, host_interrupt_out;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0]  wstrb = 4'h0, ws = 4'hF;
  logic [1:0]  bresp, rresp, rsp;
  ufh_byte_t   rx_char_data, tx_char_data;
  logic [7:0]  d;
  logic [7:0]  rxq[$], txe[$];
  int          failures = 0, cmp_count = 0, cycles = 0, i, t, n;
  int          trig[4] = '{1, 4, 8, 14};

  ufh_host_if dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .rx_char_valid, .rx_char_data, .tx_char_valid, .tx_char_ready, .tx_char_data,
    .host_interrupt_out);
  ufh_line_model line (.aclk, .rx_char_valid, .rx_char_data, .tx_char_valid, .tx_char_ready,
    .tx_char_data);

  always #50 aclk = ~aclk;

  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      $display("[FAIL] run time limit reached");
      finish_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One transfer at a time, so host strobe spacing is always met
  task automatic wr(input int idx, input logic [7:0] v);
    @(posedge aclk);
    awaddr  <= 8'(idx * 4);
    wdata   <= {24'h0, v};
    wstrb   <= ws;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input int idx);
    @(posedge aclk);
    araddr  <= 8'(idx * 4);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (1)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic ck(input string nm, input int idx, input logic [7:0] m, input logic [7:0] e);
    rd(idx);
    check(nm, rv & {24'h0, m}, {24'h0, e});
  endtask : ck

  task automatic poll(input logic [7:0] e, input int lim);
    n = 0;
    rd(2);
    while (rv !== {24'h0, e} && n < lim)
    begin
      rd(2);
      n++;
    end
  endtask : poll

  task automatic wait_tx(input int cnt);
    n = 0;
    while (line.txq.size() < cnt && n < 500)
    begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_tx

  initial
  begin
    void'($urandom(11017));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    ck("ier", 1, 8'hFF, 8'h00);
    ck("lcr", 3, 8'hFF, 8'h00);
    ck("iir", 2, 8'hFF, 8'h01);
    ck("lsr", 5, 8'h61, 8'h60);
    rd(8);
    check("rresp", rsp, 2'h2);
    check("rdata", rv, 32'h0);
    wr(9, 8'h55);
    check("bresp", rsp, 2'h2);
    d = 8'($urandom);
    wr(7, d);
    ck("scr", 7, 8'hFF, d);
    // A write with the low byte lane off must leave the register alone
    ws = 4'h0;
    wr(7, ~d);
    ws = 4'hF;
    ck("scr_nostrb", 7, 8'hFF, d);
    ck("idx4", 4, 8'hFF, 8'h00);
    $display("test registers done");
    // Single-character mode: second byte has nowhere to go
    line.send(8'h3C);
    line.send(8'h96);
    ck("rxbuf", 0, 8'hFF, 8'h3C);
    ck("lsr", 5, 8'h03, 8'h02);
    $display("test legacy done");
    wr(2, 8'h01);
    line.send(8'h5E);
    ck("iir", 2, 8'hFF, 8'hC1);
    check("irq", 32'(host_interrupt_out), 32'h0);
    ck("rxbuf", 0, 8'hFF, 8'h5E);
    $display("test masked done");
    wr(1, 8'h01);
    for (t = 0; t < 4; t++)
    begin
      wr(2, 8'(t * 64 + 3));
      n = (t == 3) ? 17 : trig[t] + 1;
      for (i = 1; i <= n; i++)
      begin
        d = 8'($urandom);
        line.send(d);
        if (rxq.size() < 16)
          rxq.push_back(d);
        ck("iir", 2, 8'hFF, (i >= trig[t]) ? 8'hC4 : 8'hC1);
        check("irq", 32'(host_interrupt_out), 32'(i >= trig[t]));
      end
      ck("lsr", 5, 8'h03, (n > 16) ? 8'h03 : 8'h01);
      while (rxq.size() > 0)
      begin
        ck("rxbuf", 0, 8'hFF, rxq.pop_front());
        ck("iir", 2, 8'hFF, (rxq.size() >= trig[t]) ? 8'hC4 : 8'hC1);
      end
      ck("lsr", 5, 8'h01, 8'h00);
      check("irq", 32'(host_interrupt_out), 32'h0);
    end
    $display("test trigger levels done");
    // Twelve-bit characters make four character times about 4170 cycles
    wr(3, 8'h0F);
    wr(2, 8'hC3);
    line.send(8'h71);
    repeat (3500) @(posedge aclk);
    ck("iir", 2, 8'hFF, 8'hC1);
    poll(8'hCC, 600);
    check("iir", rv, 32'hCC);
    check("irq", 32'(host_interrupt_out), 32'h1);
    ck("rxbuf", 0, 8'hFF, 8'h71);
    ck("iir", 2, 8'hFF, 8'hC1);
    $display("test timeout done");
    wr(1, 8'h02);
    wr(2, 8'h00);
    wr(2, 8'h07);
    ck("iir", 2, 8'hFF, 8'hC2);
    ck("iir", 2, 8'hFF, 8'hC1);
    // First empty after enabling the FIFOs must not wait a character time
    for (i = 0; i < 3; i++)
    begin
      d = 8'($urandom);
      txe.push_back(d);
      wr(0, d);
      if (i == 0)
      begin
        wait_tx(1);
        repeat (4) @(posedge aclk);
        ck("iir", 2, 8'hFF, 8'hC2);
      end
    end
    wait_tx(3);
    for (i = 0; i < 3; i++)
      check("txchar", line.txq.pop_front(), txe.pop_front());
    poll(8'hC2, 1000);
    check("iir", rv, 32'hC2);
    wr(0, 8'hE1);
    wait_tx(1);
    check("txchar", line.txq.pop_front(), 32'hE1);
    ck("iir", 2, 8'hFF, 8'hC1);
    poll(8'hC2, 1000);
    check("iir", rv, 32'hC2);
    $display("test transmit done");
    wr(3, 8'h80);
    wr(0, 8'h5A);
    wr(1, 8'hA5);
    ck("dll", 0, 8'hFF, 8'h5A);
    ck("dlm", 1, 8'hFF, 8'hA5);
    repeat (20) @(posedge aclk);
    check("txcount", line.txq.size(), 32'h0);
    $display("test divisor access done");
    finish_test();
  end
endmodule : uart_fifo_host_interface_test

/* File: tb/ufh_line_model.sv */
// Line-side model: character source into the receiver and stalling sink for the transmitter
`timescale 1ns/1ns
module ufh_line_model (
  // Clock
  input wire logic               aclk,
  // Receive stream
  output logic                   rx_char_valid,
  output ufh_pkg::ufh_byte_t     rx_char_data,
  // Transmit stream
  input wire logic               tx_char_valid,
  output logic                   tx_char_ready,
  input wire ufh_pkg::ufh_byte_t tx_char_data
);
  import ufh_pkg::*;
  ufh_byte_t txq[$];
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char_data  = 8'hA5;
    tx_char_ready = 1'b0;
  end
  task automatic send(input ufh_byte_t d);
    @(posedge aclk);
    rx_char_valid <= 1'b1;
    rx_char_data  <= d;
    @(posedge aclk);
    rx_char_valid <= 1'b0;
    // Idle data is inverted so a stale byte is never mistaken for a new one
    rx_char_data  <= ~d;
  endtask : send
  always @(posedge aclk)
  begin
    if (tx_char_valid && tx_char_ready)
      txq.push_back(tx_char_data);
    // Sink stalls about a third of the time
    tx_char_ready <= 1'(($urandom % 3) != 0);
  end
endmodule : ufh_line_model
